// >>> pdc_flush_counter.sv
`timescale 1ns/1ps
module pdc_flush_counter #(
   parameter int COUNT = 16
) (
   input  wire logic i_clk,    // Clock.
   input  wire logic i_rst_n,  // Synchronous reset, active low.
   input  wire logic i_run,    // Count while high, clear when low.
   output logic      o_done    // Count reached.
);
   localparam int CW = $clog2(COUNT + 1);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   if (COUNT < 1)
   begin : g_count_check
      $error("COUNT must be at least one");
   end

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (!i_run)
      begin
         cnt_nxt = '0;
      end
      else if (cnt_r != CW'(COUNT))
      begin
         cnt_nxt = cnt_r + 1'h1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   assign o_done = (cnt_r == CW'(COUNT));
endmodule : pdc_flush_counter

// >>> pdc_host_model.sv
`timescale 1ns/1ps
module pdc_host_model (
   input  wire logic       i_gate,  // Requested gate level.
   input  wire logic       i_we,    // Requested write strobe.
   input  wire logic [7:0] i_wdata, // Requested write data.
   output logic            o_gate,  // Transmit gate pin.
   output logic            o_we,    // Write strobe.
   output logic [7:0]      o_wdata  // Write data.
);
   assign o_gate = i_gate;
   assign o_we = i_we;
   // Idle data is inverted so a stale value can never pass for a write.
   assign o_wdata = i_we ? i_wdata : ~i_wdata;
endmodule : pdc_host_model

// >>> pdc_pkg.sv
package pdc_pkg;
   // Control register 0x00 field positions.
   localparam logic [7:0] PDC_CTRL_ADDR      = 8'h00;
   localparam int         PDC_FULL_PD_BIT    = 4;
   localparam int         PDC_AUTO_PD_EN_BIT = 3;
   localparam logic [7:0] PDC_CTRL_RESET     = 8'h00;
   // Flush count before automatic digital power-down; the flush lasts this many clock cycles plus one.
   localparam int         PDC_FLUSH_CYCLES   = 16;
   localparam int         PDC_AUX_COUNT      = 2;
   localparam int         PDC_DATA_W         = 16;

   typedef enum logic [1:0] {PDC_RUN, PDC_FLUSH, PDC_DIG_OFF} pdc_state_type;
endpackage : pdc_pkg

// >>> pdc_power_down_control.sv
`timescale 1ns/1ps
// Summary of operation
// - Digital engine, main converters and auxiliary converters power down independently or together.
// - Main converter sleep turns their outputs off while the reference stays powered.
// - Full power-down bit 4 of register 0x00 powers down all analog and digital logic except the serial port, including the reference.
// - The serial configuration port stays enabled during full power-down.
// - Each auxiliary converter can be put to sleep through its own bit of I_AUX_SLEEP.
// - Auto power-down enable bit 3 of register 0x00 selects automatic digital power-down under the transmit gate.
// - Transmit gate low with auto power-down off feeds zeros into the data path and powers nothing down.
// - Transmit gate low with auto power-down on flushes for several cycles, then powers down the digital engine.
// - Automatic digital power-down leaves converters, reference and serial port untouched.
module pdc_power_down_control
   import pdc_pkg::*;
#(
   parameter int FLUSH_CYCLES = pdc_pkg::PDC_FLUSH_CYCLES,
   parameter int AUX_COUNT    = pdc_pkg::PDC_AUX_COUNT,
   parameter int DATA_W       = pdc_pkg::PDC_DATA_W
) (
   input  wire logic              I_CLK,              // 10 MHz clock.
   input  wire logic              I_RESET_N,          // Synchronous reset, active low.
   input  wire logic              I_CFG_WE,           // Write strobe for control register 0x00.
   input  wire logic [7:0]        I_CFG_WDATA,        // Control register write data.
   input  wire logic              I_MAIN_SLEEP,       // Main converter sleep request.
   input  wire logic              I_MAIN_PD,          // Main converter power-down request.
   input  wire logic              I_DIG_PD,           // Digital engine power-down request.
   input  wire logic [AUX_COUNT-1:0] I_AUX_SLEEP,     // Per auxiliary converter sleep.
   input  wire logic              I_TRANSMIT_GATE_INPUT, // Transmit gate, high for normal operation.
   input  wire logic [DATA_W-1:0] I_DATA,             // Sample into the data path.
   output logic [7:0]             O_CFG_RDATA,        // Control register readback.
   output logic [DATA_W-1:0]      O_DATA,             // Sample out of the data path.
   output logic                   O_DIG_PWR_DOWN,     // Digital engine powered down.
   output logic                   O_MAIN_OUT_OFF,     // Main converter outputs off.
   output logic                   O_MAIN_CORE_DOWN,   // Main converter cores powered down.
   output logic                   O_REF_DOWN,         // Reference powered down.
   output logic [AUX_COUNT-1:0]   O_AUX_DOWN,         // Auxiliary converters asleep.
   output logic                   O_CFG_PORT_EN,      // Serial port enabled.
   output logic [1:0]             O_STATE             // Auto power-down state.
);
   import pdc_pkg::*;

   // Sizes that the flush counter and the ports cannot serve are refused while elaborating.
   if (FLUSH_CYCLES < 1 || AUX_COUNT < 1 || DATA_W < 1)
   begin : g_param_check
      $error("Parameters out of range");
   end

   logic [7:0]          ctrl_r;
   logic [7:0]          ctrl_nxt;
   pdc_state_type       state_r;
   pdc_state_type       state_nxt;
   logic [DATA_W-1:0]   data_r;
   logic [DATA_W-1:0]   data_nxt;
   logic                flush_done;
   logic                full_pd;
   logic                auto_en;

   assign full_pd = ctrl_r[PDC_FULL_PD_BIT];
   assign auto_en = ctrl_r[PDC_AUTO_PD_EN_BIT];

   // Clearing the enable bit abandons a flush at once, so software can wake the engine without the gate.
   function automatic logic auto_request(input logic gate, input logic enable);
      return !gate && enable;
   endfunction : auto_request

   // The register is always writable so software can wake the part from full power-down.
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (I_CFG_WE)
      begin
         ctrl_nxt = I_CFG_WDATA;
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         PDC_RUN:
         begin
            if (auto_request(I_TRANSMIT_GATE_INPUT, auto_en))
            begin
               state_nxt = PDC_FLUSH;
            end
         end
         PDC_FLUSH:
         begin
            if (!auto_request(I_TRANSMIT_GATE_INPUT, auto_en))
            begin
               state_nxt = PDC_RUN;
            end
            else if (flush_done)
            begin
               state_nxt = PDC_DIG_OFF;
            end
         end
         PDC_DIG_OFF:
         begin
            if (!auto_request(I_TRANSMIT_GATE_INPUT, auto_en))
            begin
               state_nxt = PDC_RUN;
            end
         end
         default:
         begin
            state_nxt = PDC_RUN;
         end
      endcase
   end

   always_comb
   begin
      data_nxt = I_DATA;
      if (!I_TRANSMIT_GATE_INPUT || state_r != PDC_RUN)
      begin
         data_nxt = '0;
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         ctrl_r <= PDC_CTRL_RESET;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         state_r <= PDC_RUN;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         data_r <= '0;
      end
      else
      begin
         data_r <= data_nxt;
      end
   end

   // The count starts on the first flush cycle, so the flush lasts FLUSH_CYCLES + 1 cycles and power-down comes FLUSH_CYCLES + 2 rising edges after the gate falls.
   pdc_flush_counter #(
      .COUNT (FLUSH_CYCLES)
   ) u_flush (
      .i_clk   (I_CLK),
      .i_rst_n (I_RESET_N),
      .i_run   (state_r == PDC_FLUSH),
      .o_done  (flush_done)
   );

   // Auto power-down touches only the digital engine; converters follow their own controls.
   assign O_DIG_PWR_DOWN   = full_pd || I_DIG_PD || (state_r == PDC_DIG_OFF);
   assign O_MAIN_OUT_OFF   = full_pd || I_MAIN_SLEEP || I_MAIN_PD;
   assign O_MAIN_CORE_DOWN = full_pd || I_MAIN_PD;
   assign O_REF_DOWN       = full_pd;
   assign O_AUX_DOWN       = I_AUX_SLEEP | {AUX_COUNT{full_pd}};
   assign O_CFG_PORT_EN    = 1'h1;
   assign O_CFG_RDATA      = ctrl_r;
   assign O_DATA           = data_r;
   assign O_STATE          = state_r;

   a_full_pd_all: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      full_pd |-> (O_DIG_PWR_DOWN && O_REF_DOWN && O_MAIN_CORE_DOWN && (&O_AUX_DOWN)))
      else $error("Full power-down left something on");
   a_sleep_keeps_ref: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_MAIN_SLEEP && !full_pd) |-> (O_MAIN_OUT_OFF && !O_REF_DOWN))
      else $error("Sleep changed reference or outputs");
   a_port_alive: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CFG_WE) |=> (O_CFG_RDATA == $past(I_CFG_WDATA)))
      else $error("Register write lost");
   a_aux_sleep: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_AUX_DOWN == (I_AUX_SLEEP | {AUX_COUNT{full_pd}}))
      else $error("Aux sleep wrong");
   a_gate_no_auto: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (!I_TRANSMIT_GATE_INPUT && !auto_en && !full_pd && !I_CFG_WE) |=> (O_DATA == '0 && O_DIG_PWR_DOWN == I_DIG_PD))
      else $error("Zero flush without power-down failed");
   a_auto_flush_time: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (state_r == PDC_RUN && !I_TRANSMIT_GATE_INPUT && auto_en)
      ##1 (!I_TRANSMIT_GATE_INPUT && auto_en && !I_CFG_WE) [*2] |-> state_r == PDC_FLUSH)
      else $error("Flush not entered");
   a_auto_no_analog: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (state_r == PDC_DIG_OFF && !full_pd) |-> (!O_REF_DOWN && O_CFG_PORT_EN))
      else $error("Auto power-down hit analog");
   a_gate_restore: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_TRANSMIT_GATE_INPUT && state_r == PDC_DIG_OFF) |=> state_r == PDC_RUN)
      else $error("Digital engine not restored");
   a_auto_en_ctrl: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (!auto_en) |=> (state_r == PDC_RUN))
      else $error("Auto state with enable clear");
   a_indep_dig: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_DIG_PD && !full_pd && !I_MAIN_SLEEP && !I_MAIN_PD) |-> (O_DIG_PWR_DOWN && !O_MAIN_OUT_OFF))
      else $error("Power domains not independent");
   a_flush_hold: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (state_r == PDC_FLUSH && !flush_done && !I_TRANSMIT_GATE_INPUT && auto_en) |=> state_r == PDC_FLUSH)
      else $error("Digital engine powered down before the flush ended");
   a_flush_length: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (state_r == PDC_FLUSH && flush_done && !I_TRANSMIT_GATE_INPUT && auto_en) |=> state_r == PDC_DIG_OFF)
      else $error("Digital engine not powered down after the flush");
   a_flush_zero: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (state_r != PDC_RUN) |=> (O_DATA == '0))
      else $error("Data passed while flushing or powered down");
   a_data_pass: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_TRANSMIT_GATE_INPUT && state_r == PDC_RUN) |=> (O_DATA == $past(I_DATA)))
      else $error("Data not passed in normal operation");
   a_main_core: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (I_MAIN_PD && !full_pd) |-> (O_MAIN_CORE_DOWN && O_MAIN_OUT_OFF && !O_REF_DOWN))
      else $error("Main converter power-down wrong");
endmodule : pdc_power_down_control

// >>> power_down_control_test.sv
`timescale 1ns/1ps
module power_down_control_test;
   import pdc_pkg::*;
   localparam int FC = 2;
   logic clk = 0, rst_n = 0, we_r = 0, gate_r = 1, msl = 0, mpd = 0, dpd = 0;
   logic [7:0] wd_r = 8'h00;
   logic [1:0] aux = 2'h0;
   logic [15:0] din = 16'h0000;
   logic gate, we, pen, dig, moff, mcore, refd;
   logic [7:0] wd, rdata;
   logic [15:0] dout;
   logic [1:0] auxd, st;
   logic [11:0] rows [8] = '{12'h000, 12'h410, 12'h218, 12'h120, 12'h041, 12'h1A2, 12'h83F, 12'h87F};
   int err_total = 0, total_checks = 0, cyc = 0;
   pdc_host_model host (.i_gate(gate_r), .i_we(we_r), .i_wdata(wd_r), .o_gate(gate), .o_we(we), .o_wdata(wd));
   pdc_power_down_control #(.FLUSH_CYCLES(FC)) dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_CFG_WE(we),
      .I_CFG_WDATA(wd), .I_MAIN_SLEEP(msl), .I_MAIN_PD(mpd), .I_DIG_PD(dpd), .I_AUX_SLEEP(aux),
      .I_TRANSMIT_GATE_INPUT(gate), .I_DATA(din), .O_CFG_RDATA(rdata), .O_DATA(dout), .O_DIG_PWR_DOWN(dig),
      .O_MAIN_OUT_OFF(moff), .O_MAIN_CORE_DOWN(mcore), .O_REF_DOWN(refd), .O_AUX_DOWN(auxd),
      .O_CFG_PORT_EN(pen), .O_STATE(st));
   initial forever #50 clk = ~clk;
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] v);
      we_r = 1;
      wd_r = v;
      tick(1);
      we_r = 0;
   endtask : wr
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_total++;
         print_verdict();
      end
   end
   initial
   begin
      tick(5);
      rst_n = 1;
      tick(1);
      chk("reset ctrl", rdata, PDC_CTRL_RESET);
      chk("reset state", st, PDC_RUN);
      chk("reset data", dout, 16'h0000);
      $display("test reset done");
      foreach (rows[i])
      begin
         wr(rows[i][11] ? 8'h10 : 8'h00);
         {msl, mpd, dpd, aux} = rows[i][10:6];
         tick(1);
         chk("power outputs", {dig, moff, mcore, refd, auxd}, rows[i][5:0]);
         chk("ctrl readback", rdata, rows[i][11] ? 8'h10 : 8'h00);
         chk("port enable", pen, 1'b1);
      end
      {msl, mpd, dpd, aux} = 5'h00;
      wr(8'h00);
      $display("test table done");
      din = 16'hA5C3;
      tick(2);
      chk("pass data", dout, 16'hA5C3);
      gate_r = 0;
      tick(2);
      chk("zero fill", dout, 16'h0000);
      chk("no power down", {dig, st}, {1'b0, PDC_RUN});
      $display("test zero fill done");
      gate_r = 1;
      wr(8'h08);
      gate_r = 0;
      chk("auto enable", rdata, 8'h08);
      tick(1);
      chk("flush state", st, PDC_FLUSH);
      chk("flush data", dout, 16'h0000);
      tick(FC);
      chk("still flushing", {dig, st}, {1'b0, PDC_FLUSH});
      tick(1);
      chk("dig off", {dig, st}, {1'b1, PDC_DIG_OFF});
      chk("others kept", {moff, mcore, refd, auxd, pen}, 6'h01);
      gate_r = 1;
      tick(1);
      chk("restore", st, PDC_RUN);
      tick(1);
      chk("resume data", dout, 16'hA5C3);
      chk("resume power", dig, 1'h0);
      $display("test auto power down done");
      gate_r = 0;
      tick(1);
      chk("flush before reset", st, PDC_FLUSH);
      rst_n = 0;
      tick(1);
      chk("mid reset ctrl", rdata, PDC_CTRL_RESET);
      chk("mid reset state", st, PDC_RUN);
      chk("mid reset data", dout, 16'h0000);
      rst_n = 1;
      tick(1);
      chk("no auto after reset", {dig, st}, {1'h0, PDC_RUN});
      chk("zero after reset", dout, 16'h0000);
      $display("test mid reset done");
      print_verdict();
   end
endmodule : power_down_control_test
